// file: src/vgaat_stage.sv
`timescale 1ns/10ps
module vgaat_stage
    import vgaat_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Host shared port
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_rdata,
    output logic            o_is_data,
    // Serialiser side
    input  wire logic [3:0] i_planes,
    input  wire logic [7:0] i_char,
    input  wire logic [7:0] i_attr,
    input  wire logic       i_fg,
    input  wire logic       i_ul,
    input  wire logic       i_col9,
    input  wire logic       i_cell9,
    input  wire logic       i_deep,
    input  wire logic       i_active,
    input  wire logic       i_border,
    input  wire logic       i_vsync,
    input  wire logic       i_line_match,
    // Lookup table and panel
    output logic      [7:0] o_lut_addr,
    output logic      [7:0] o_panel,
    output logic            o_pix_adv,
    output logic      [1:0] o_status
);
    import vgaat_pkg::*;

    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    logic [7:0]       mode;
    logic [5:0]       bcol;
    logic [5:0]       plane;
    logic [3:0]       pan;
    logic [3:0]       page;
    logic             viden;
    logic [15:0][5:0] pal;

    vgaat_regs u_regs (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_wr      (i_wr),
        .i_rd      (i_rd),
        .i_wdata   (i_wdata),
        .o_rdata   (o_rdata),
        .o_is_data (o_is_data),
        .o_mode    (mode),
        .o_border  (bcol),
        .o_plane   (plane),
        .o_pan     (pan),
        .o_page    (page),
        .o_viden   (viden),
        .o_pal     (pal)
    );

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    typedef struct packed {
        logic       phase;
        logic       pan_zero;
        logic [4:0] vcount;
        logic       blink;
        logic       vs_d;
        logic [7:0] lut;
        logic [7:0] panel;
        logic [1:0] stat;
    } vgaat_st_s;

    vgaat_st_s s;
    vgaat_st_s next_s;

    logic [7:0] pix_raw;
    logic [7:0] pix_pan;
    logic [3:0] pan_sel;
    logic [3:0] pan_eff;
    logic       adv;
    logic       vs_edge;

    assign adv = ~mode[VGAAT_M_DBL] | s.phase;                   // [R2]
    assign vs_edge = i_vsync & ~s.vs_d;
    assign pan_eff = s.pan_zero ? 4'h0 : pan;                    // [R3]

    // Map register value to tap selection
    function automatic logic [3:0] pan_map(input logic [3:0] v,
                                           input logic c9,
                                           input logic m13);
        logic [3:0] n;
        n = 4'h0;
        if (m13) begin
            n = {1'b0, v[3:1]};                                  // [R13]
        end else if (v[3]) begin
            n = c9 ? 4'h0 : 4'h9;                                // [R12]
        end else begin
            n = c9 ? v + 4'h1 : v;                               // [R12]
        end
        return n;
    endfunction : pan_map

    assign pan_sel = pan_map(pan_eff, i_cell9 & ~mode[VGAAT_M_GFX],
                             mode[VGAAT_M_DBL]);

    // -------------------------------------------------------------------
    // Pixel formation
    // -------------------------------------------------------------------
    always_comb begin
        logic [3:0] nib;
        logic       fgon;
        logic [3:0] fgc;
        logic [3:0] bgc;
        nib  = 4'h0;
        fgon = 1'b0;
        fgc  = i_attr[3:0];
        bgc  = i_attr[7:4];
        pix_raw = 8'h00;
        if (mode[VGAAT_M_GFX]) begin                             // [R8]
            nib = i_planes;
        end else begin
            fgon = i_col9 ? (mode[VGAAT_M_LGFX] && i_char >= VGAAT_LG_LO
                             && i_char <= VGAAT_LG_HI && i_fg)   // [R5]
                          : i_fg;
            if (mode[VGAAT_M_BLINK]) begin                       // [R4]
                bgc[3] = 1'b0;
                if (i_attr[7] && s.blink) begin
                    fgon = 1'b0;
                end
            end
            if (mode[VGAAT_M_MONO]) begin                        // [R6]
                bgc = (i_attr[6:4] == VGAAT_REV_BG) ? VGAAT_MONO_FG
                                                    : 4'h0;      // [R7]
                fgc = (i_attr[2:0] == 3'h0) ? 4'h0
                    : (i_attr[3] ? VGAAT_MONO_HI : VGAAT_MONO_FG);
                if (i_ul && i_attr[2:0] == VGAAT_UL_FG) begin    // [R7]
                    fgon = 1'b1;
                end
            end
            nib = fgon ? fgc : bgc;
        end
        nib = nib & plane[3:0];                                  // [R11]
        pix_raw = {4'h0, nib};
        if (i_deep) begin
            pix_raw = {i_attr};
        end
    end

    vgaat_pan u_pan (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_adv (adv),
        .i_pix (pix_raw),
        .i_sel (pan_sel),
        .o_pix (pix_pan)
    );

    // -------------------------------------------------------------------
    // Address and control update
    // -------------------------------------------------------------------
    always_comb begin
        logic [5:0] pv;
        logic [7:0] a;
        a = 8'h00;
        next_s = s;
        pv = pal[pix_pan[3:0]];                                  // [R16]
        next_s.phase = mode[VGAAT_M_DBL] ? ~s.phase : 1'b1;      // [R2]
        next_s.vs_d = i_vsync;
        if (vs_edge) begin
            next_s.pan_zero = 1'b0;                              // [R3]
            next_s.vcount = s.vcount + 5'h1;
            if (s.vcount == VGAAT_BLINK_DIV) begin
                next_s.blink = ~s.blink;                         // [R4]
            end
        end
        if (i_line_match && mode[VGAAT_M_PANC]) begin
            next_s.pan_zero = 1'b1;                              // [R3]
        end
        if (!mode[VGAAT_M_PANC]) begin
            next_s.pan_zero = 1'b0;
        end
        if (i_deep || mode[VGAAT_M_DBL]) begin
            a = pix_pan;                                         // [R2]
        end else begin
            a = {page[3:2], pv};                                 // [R14]
            if (mode[VGAAT_M_PAGE]) begin
                a[5:4] = page[1:0];                              // [R1] [R15]
            end
        end
        if (i_border || !viden) begin
            a = {2'b00, bcol};                                   // [R9]
        end else if (!i_active) begin
            a = 8'h00;
        end
        if (adv) begin
            next_s.lut = a;
            next_s.panel = a;
        end
        unique case (plane[5:4])                                 // [R10]
            2'b00: next_s.stat = {s.panel[2], s.panel[0]};
            2'b01: next_s.stat = {s.panel[3], s.panel[1]};
            2'b10: next_s.stat = {s.panel[5], s.panel[4]};
            2'b11: next_s.stat = {s.panel[7], s.panel[6]};
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_lut_addr = s.lut;
    assign o_panel    = s.panel;
    assign o_pix_adv  = adv;
    assign o_status   = s.stat;

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    property p_border;
        @(posedge i_clk) disable iff (i_rst)
        (i_border && adv) |=> (o_lut_addr == {2'b00, $past(bcol)});
    endproperty
    a_border: assert property (p_border) // [R9]
        else $error("border colour not shown");

    property p_dbl;
        @(posedge i_clk) disable iff (i_rst)
        (mode[VGAAT_M_DBL] && $past(mode[VGAAT_M_DBL])) |-> adv != $past(adv);
    endproperty
    a_dbl: assert property (p_dbl) // [R2]
        else $error("double clock did not alternate");

    property p_stat;
        @(posedge i_clk) disable iff (i_rst)
        (plane[5:4] == 2'b11) |=> o_status == $past({o_panel[7], o_panel[6]});
    endproperty
    a_stat: assert property (p_stat) // [R10]
        else $error("status mux wrong pair");

    sequence s_match;
        mode[VGAAT_M_PANC] && i_line_match && !vs_edge;
    endsequence
    property p_panc;
        @(posedge i_clk) disable iff (i_rst)
        s_match ##1 !vs_edge |-> pan_eff == 4'h0;
    endproperty
    a_panc: assert property (p_panc) // [R3]
        else $error("pan not forced to zero");

    property p_page;
        @(posedge i_clk) disable iff (i_rst)
        (adv && mode[VGAAT_M_PAGE] && !mode[VGAAT_M_DBL] && !i_deep
         && i_active && !i_border && viden)
        |=> o_lut_addr[5:4] == $past(page[1:0]);
    endproperty
    a_page: assert property (p_page) // [R1]
        else $error("page bits not used");

    property p_csel;
        @(posedge i_clk) disable iff (i_rst)
        (adv && !mode[VGAAT_M_DBL] && !i_deep && i_active && !i_border
         && viden) |=> o_panel[7:6] == $past(page[3:2]);
    endproperty
    a_csel: assert property (p_csel) // [R14]
        else $error("colour select bits missing");

    property p_plane;
        @(posedge i_clk) disable iff (i_rst)
        (!i_deep && mode[VGAAT_M_GFX]) |->
        pix_raw[3:0] == (i_planes & plane[3:0]);
    endproperty
    a_plane: assert property (p_plane) // [R11]
        else $error("disabled plane leaked");

    property p_pan0;
        @(posedge i_clk) disable iff (i_rst)
        (!mode[VGAAT_M_DBL] && !i_cell9 && pan_eff == 4'h0) |->
        pan_sel == 4'h0;
    endproperty
    a_pan0: assert property (p_pan0) // [R12]
        else $error("eight-pixel pan zero shifted");

    property p_viden;
        @(posedge i_clk) disable iff (i_rst)
        (adv && !viden) |=> o_lut_addr == {2'b00, $past(bcol)};
    endproperty
    a_viden: assert property (p_viden) // [R9]
        else $error("video disable did not show border");

    property p_panclr;
        @(posedge i_clk) disable iff (i_rst)
        (vs_edge && !i_line_match) |=> pan_eff == pan;
    endproperty
    a_panclr: assert property (p_panclr) // [R3]
        else $error("pan not restored after vsync");

    property p_blink;
        @(posedge i_clk) disable iff (i_rst)
        !(vs_edge && s.vcount == VGAAT_BLINK_DIV) |=>
        s.blink == $past(s.blink);
    endproperty
    a_blink: assert property (p_blink) // [R4]
        else $error("blink toggled off the 32nd vsync");

    property p_pan8r;
        @(posedge i_clk) disable iff (i_rst)
        (!mode[VGAAT_M_DBL] && !(i_cell9 && !mode[VGAAT_M_GFX])
         && pan_eff[3]) |-> pan_sel == 4'h9;
    endproperty
    a_pan8r: assert property (p_pan8r) // [R12]
        else $error("eight-pixel high pan not right shift");

    property p_pan9;
        @(posedge i_clk) disable iff (i_rst)
        (!mode[VGAAT_M_DBL] && i_cell9 && !mode[VGAAT_M_GFX]
         && pan_eff[3]) |-> pan_sel == 4'h0;
    endproperty
    a_pan9: assert property (p_pan9) // [R12]
        else $error("nine-pixel high pan shifted");
endmodule : vgaat_stage

// file: src/vgaat_pkg.sv
// Notes on behaviour
// R1 - Page bit picks address bits 5:4 source
// R2 - Double clock halves pixel rate, bypasses palette
// R3 - Compat bit zeroes pan after line match
// R4 - Blink toggles every 32 vertical syncs
// R5 - Ninth column copies eighth for C0-DF
// R6 - Display type selects mono attribute meaning
// R7 - Mono attribute: blink, bg, intensity, fg
// R8 - Graphics bit selects text or graphics
// R9 - Border region shows border colour entry
// R10 - Status mux routes panel bit pairs
// R11 - Plane enables gate plane bits
// R12 - Fine pan shifts per cell width
// R13 - Mode 13h pan uses even values halved
// R14 - Colour select bits form address 7:6
// R15 - Page bits also drive panel 5:4
// R16 - Pixel nibble selects palette entry
// R17 - Shared port toggles index and data
// R18 - Reserved bits read zero
package vgaat_pkg;
    // -------------------------------------------------------------------
    // Register indices
    // -------------------------------------------------------------------
    localparam logic [4:0] VGAAT_IDX_MODE   = 5'h10;
    localparam logic [4:0] VGAAT_IDX_BORDER = 5'h11;
    localparam logic [4:0] VGAAT_IDX_PLANE  = 5'h12;
    localparam logic [4:0] VGAAT_IDX_PAN    = 5'h13;
    localparam logic [4:0] VGAAT_IDX_PAGE   = 5'h14;
    localparam logic [4:0] VGAAT_IDX_PALMAX = 5'h0f;
    // -------------------------------------------------------------------
    // Mode register fields
    // -------------------------------------------------------------------
    localparam int VGAAT_M_PAGE   = 7;
    localparam int VGAAT_M_DBL    = 6;
    localparam int VGAAT_M_PANC   = 5;
    localparam int VGAAT_M_BLINK  = 3;
    localparam int VGAAT_M_LGFX   = 2;
    localparam int VGAAT_M_MONO   = 1;
    localparam int VGAAT_M_GFX    = 0;
    localparam logic [7:0] VGAAT_MODE_MASK  = 8'hef;
    localparam logic [7:0] VGAAT_PAL_MASK   = 8'h3f;
    localparam logic [7:0] VGAAT_PLANE_MASK = 8'h3f;
    localparam logic [7:0] VGAAT_PAN_MASK   = 8'h0f;
    localparam logic [7:0] VGAAT_PAGE_MASK  = 8'h0f;
    localparam logic [7:0] VGAAT_IDX_MASK   = 8'h3f;
    localparam int VGAAT_IDX_VIDEN = 5;
    localparam logic [7:0] VGAAT_RST = 8'h00;
    // -------------------------------------------------------------------
    // Character and blink constants
    // -------------------------------------------------------------------
    localparam logic [7:0] VGAAT_LG_LO = 8'hc0;
    localparam logic [7:0] VGAAT_LG_HI = 8'hdf;
    localparam logic [4:0] VGAAT_BLINK_DIV = 5'h1f;
    localparam logic [2:0] VGAAT_UL_FG = 3'h1;
    localparam logic [2:0] VGAAT_REV_BG = 3'h7;
    localparam logic [3:0] VGAAT_MONO_FG = 4'h7;
    localparam logic [3:0] VGAAT_MONO_HI = 4'hf;
endpackage : vgaat_pkg

// file: src/vgaat_regs.sv
`timescale 1ns/10ps
module vgaat_regs
    import vgaat_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Shared port
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_rdata,
    output logic            o_is_data,
    // Fields
    output logic      [7:0] o_mode,
    output logic      [5:0] o_border,
    output logic      [5:0] o_plane,
    output logic      [3:0] o_pan,
    output logic      [3:0] o_page,
    output logic            o_viden,
    output logic [15:0][5:0] o_pal
);
    import vgaat_pkg::*;

    typedef struct packed {
        logic            flip;
        logic [5:0]      idx;
        logic [7:0]      mode;
        logic [5:0]      border;
        logic [5:0]      plane;
        logic [3:0]      pan;
        logic [3:0]      page;
        logic [15:0][5:0] pal;
    } vgaat_regs_s;

    vgaat_regs_s r;
    vgaat_regs_s next_r;

    always_comb begin
        next_r = r;
        if (i_wr) begin
            next_r.flip = ~r.flip;                              // [R17]
            if (!r.flip) begin
                next_r.idx = i_wdata[5:0];                      // [R18]
            end else if (r.idx[4:0] <= VGAAT_IDX_PALMAX) begin
                next_r.pal[r.idx[3:0]] = i_wdata[5:0];          // [R18]
            end else begin
                unique case (r.idx[4:0])
                    VGAAT_IDX_MODE:   next_r.mode = i_wdata & VGAAT_MODE_MASK;
                    VGAAT_IDX_BORDER: next_r.border = i_wdata[5:0];
                    VGAAT_IDX_PLANE:  next_r.plane = i_wdata[5:0];
                    VGAAT_IDX_PAN:    next_r.pan = i_wdata[3:0];
                    VGAAT_IDX_PAGE:   next_r.page = i_wdata[3:0];
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Readback, reserved bits zero
    always_comb begin
        o_rdata = 8'h00;
        if (r.idx[4:0] <= VGAAT_IDX_PALMAX) begin
            o_rdata = {2'b00, r.pal[r.idx[3:0]]};               // [R18]
        end else begin
            unique case (r.idx[4:0])
                VGAAT_IDX_MODE:   o_rdata = r.mode;
                VGAAT_IDX_BORDER: o_rdata = {2'b00, r.border};
                VGAAT_IDX_PLANE:  o_rdata = {2'b00, r.plane};
                VGAAT_IDX_PAN:    o_rdata = {4'h0, r.pan};
                VGAAT_IDX_PAGE:   o_rdata = {4'h0, r.page};
                default:          o_rdata = 8'h00;
            endcase
        end
    end

    assign o_is_data = r.flip;
    assign o_mode    = r.mode;
    assign o_border  = r.border;
    assign o_plane   = r.plane;
    assign o_pan     = r.pan;
    assign o_page    = r.page;
    assign o_viden   = r.idx[VGAAT_IDX_VIDEN];
    assign o_pal     = r.pal;

    property p_toggle;
        @(posedge i_clk) disable iff (i_rst)
        i_wr |=> (r.flip != $past(r.flip));
    endproperty
    a_toggle: assert property (p_toggle) // [R17]
        else $error("port toggle did not alternate");

    property p_resv;
        @(posedge i_clk) disable iff (i_rst)
        (r.idx[4:0] == VGAAT_IDX_PAN) |-> (o_rdata[7:4] == 4'h0);
    endproperty
    a_resv: assert property (p_resv) // [R18]
        else $error("reserved bits read non-zero");
endmodule : vgaat_regs

// file: src/vgaat_pan.sv
`timescale 1ns/10ps
module vgaat_pan
    import vgaat_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Pixel in
    input  wire logic       i_adv,
    input  wire logic [7:0] i_pix,
    // Shift select, 0..9: 0 none, 1 left by one, 2..8 left by two, 9 right by one
    input  wire logic [3:0] i_sel,
    // Pixel out
    output logic      [7:0] o_pix
);
    import vgaat_pkg::*;

    typedef struct packed {
        logic [9:0][7:0] line;
    } vgaat_pan_s;

    vgaat_pan_s r;
    vgaat_pan_s next_r;

    always_comb begin
        next_r = r;
        if (i_adv) begin
            next_r.line = {r.line[8:0], i_pix};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Tap 1 is nominal; lower taps show later pixels (left shift)
    always_comb begin
        if (i_sel == 4'h9) begin
            o_pix = r.line[2];
        end else if (i_sel == 4'h0) begin
            o_pix = r.line[1];
        end else begin
            o_pix = (i_sel == 4'h1) ? r.line[0] : i_pix;
        end
    end
endmodule : vgaat_pan

// file: test/vgaat_video_src.sv
`timescale 1ns/10ps
module vgaat_video_src (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Pixel requests: flags are fg, ul, col9, cell9
    input  wire logic       i_adv,
    input  wire logic [3:0] i_planes,
    input  wire logic [7:0] i_char,
    input  wire logic [7:0] i_attr,
    input  wire logic [3:0] i_flags,
    input  wire logic [2:0] i_mode,
    // Serialiser outputs: mode is deep, active, border
    output logic      [3:0] o_planes,
    output logic      [7:0] o_char,
    output logic      [7:0] o_attr,
    output logic      [3:0] o_flags,
    output logic      [2:0] o_mode,
    output logic            o_vsync,
    output logic            o_line_match
);
    logic [5:0] frame_cnt;

    // ----------------------------------------------------------------
    // Pixel fetch, only on stage advance
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            {o_planes, o_char, o_attr, o_flags, o_mode} <= '0;
            frame_cnt <= 6'h00;
        end else begin
            frame_cnt <= frame_cnt + 6'h01;
            if (i_adv) begin
                {o_planes, o_char, o_attr, o_flags, o_mode} <=
                    {i_planes, i_char, i_attr, i_flags, i_mode};
            end
        end
    end

    // Short frame: vsync every 64 clocks, line match mid-frame
    assign o_vsync      = (frame_cnt < 6'h04);
    assign o_line_match = (frame_cnt == 6'h20);
endmodule : vgaat_video_src

// file: test/vga_attribute_pixel_stage_tb.sv
`timescale 1ns/10ps
module vga_attribute_pixel_stage_tb;
    import vgaat_pkg::*;
    logic       i_clk = 1'b0;
    logic       i_rst = 1'b1;
    logic       i_wr  = 1'b0;
    logic       i_rd  = 1'b0;
    logic [7:0] i_wdata = 8'h00;
    logic [3:0] px_planes = 4'h0;
    logic [7:0] px_char = 8'h00;
    logic [7:0] px_attr = 8'h00;
    logic [3:0] px_flags = 4'h0;
    logic [2:0] px_mode = 3'b010;
    logic [7:0] o_rdata, o_lut_addr, o_panel, s_char, s_attr;
    logic [3:0] s_planes, s_flags;
    logic [2:0] s_mode;
    logic [1:0] o_status;
    logic       o_is_data, o_pix_adv, s_vsync, s_lm;
    int         error_cnt = 0;
    int         tests_run = 0;

    always #2 i_clk = ~i_clk;

    vgaat_stage u_vgaat_stage (
        .i_clk(i_clk), .i_rst(i_rst), .i_wr(i_wr), .i_rd(i_rd),
        .i_wdata(i_wdata), .o_rdata(o_rdata), .o_is_data(o_is_data),
        .i_planes(s_planes), .i_char(s_char), .i_attr(s_attr),
        .i_fg(s_flags[3]), .i_ul(s_flags[2]), .i_col9(s_flags[1]),
        .i_cell9(s_flags[0]), .i_deep(s_mode[2]), .i_active(s_mode[1]),
        .i_border(s_mode[0]), .i_vsync(s_vsync), .i_line_match(s_lm),
        .o_lut_addr(o_lut_addr), .o_panel(o_panel),
        .o_pix_adv(o_pix_adv), .o_status(o_status));

    vgaat_video_src u_vgaat_video_src (
        .i_clk(i_clk), .i_rst(i_rst), .i_adv(o_pix_adv),
        .i_planes(px_planes), .i_char(px_char), .i_attr(px_attr),
        .i_flags(px_flags), .i_mode(px_mode), .o_planes(s_planes),
        .o_char(s_char), .o_attr(s_attr), .o_flags(s_flags),
        .o_mode(s_mode), .o_vsync(s_vsync), .o_line_match(s_lm));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic summarize;
        $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask : wr

    // Index with video enable set, then data
    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
        wr(idx | 8'h20);
        wr(d);
    endtask : reg_wr

    task automatic rchk(input logic [7:0] idx, d, exp);
        reg_wr(idx, d);
        #1;
        chk(o_rdata, exp);
        chk({7'h0, o_is_data}, 8'h00);
    endtask : rchk

    task automatic settle;
        repeat (16) @(posedge i_clk);
        #1;
    endtask : settle

    task automatic px(input logic [2:0] m, input logic [3:0] pl,
                      input logic [7:0] ch, at, input logic [3:0] fl);
        @(posedge i_clk);
        px_mode   <= m;
        px_planes <= pl;
        px_char   <= ch;
        px_attr   <= at;
        px_flags  <= fl;
        settle();
    endtask : px

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        @(posedge i_clk);
        #1;
        chk({7'h0, o_is_data}, 8'h00);
        chk(o_rdata, 8'h00);
        wr(8'h30);
        #1;
        chk({7'h0, o_is_data}, 8'h01);
        wr(8'hff);
        #1;
        chk(o_rdata, 8'hef);
        rchk(8'h11, 8'hff, 8'h3f);
        rchk(8'h12, 8'hff, 8'h3f);
        rchk(8'h13, 8'hff, 8'h0f);
        rchk(8'h14, 8'hff, 8'h0f);
        for (int i = 0; i < 16; i++)
            rchk(8'(i), 8'he0 | 8'(i), 8'h20 | 8'(i));
        wr(8'h35);
        wr(8'haa);
        #1;
        chk({7'h0, o_is_data}, 8'h00);
        $display("test regs done");
    endtask : t_regs

    task automatic t_gfx;
        logic [7:0] md[5], pg[5], en[5], ex[5];
        logic [3:0] pl[5];
        md = '{8'h01, 8'h01, 8'h01, 8'h81, 8'h01};
        pg = '{8'h00, 8'h00, 8'h0c, 8'h0d, 8'h0d};
        en = '{8'h0f, 8'h03, 8'h0f, 8'h0f, 8'h0f};
        pl = '{4'hb, 4'hb, 4'h5, 4'h5, 4'h5};
        ex = '{8'h2b, 8'h23, 8'he5, 8'hd5, 8'he5};
        for (int i = 0; i < 5; i++) begin
            reg_wr(8'h10, md[i]);
            reg_wr(8'h14, pg[i]);
            reg_wr(8'h12, en[i]);
            px(3'b010, pl[i], 8'h00, 8'h00, 4'h0);
            chk(o_lut_addr, ex[i]);
            chk(o_panel, ex[i]);
        end
        reg_wr(8'h10, 8'h81);
        reg_wr(8'h14, 8'h0f);
        px(3'b110, 4'h5, 8'h00, 8'h5a, 4'h0);
        chk(o_lut_addr, 8'h5a);
        $display("test gfx done");
    endtask : t_gfx

    task automatic t_status;
        logic [7:0] st;
        st = 8'h63;
        reg_wr(8'h10, 8'h01);
        reg_wr(8'h14, 8'h04);
        for (int m = 0; m < 4; m++) begin
            reg_wr(8'h12, 8'h0f | 8'(m << 4));
            px(3'b010, 4'h5, 8'h00, 8'h00, 4'h0);
            chk({6'h0, o_status}, {6'h0, st[2*m+:2]});
        end
        $display("test status done");
    endtask : t_status

    task automatic t_border;
        reg_wr(8'h14, 8'h00);
        reg_wr(8'h11, 8'hff);
        px(3'b001, 4'h5, 8'h00, 8'h00, 4'h0);
        chk(o_lut_addr, 8'h3f);
        px(3'b010, 4'h5, 8'h00, 8'h00, 4'h0);
        wr(8'h11);
        wr(8'h2a);
        settle();
        chk(o_lut_addr, 8'h2a);
        reg_wr(8'h11, 8'h2a);
        settle();
        chk(o_lut_addr, 8'h25);
        $display("test border done");
    endtask : t_border

    task automatic t_text;
        logic [7:0] ch[4], ce[4], ma[8], me[8];
        logic [3:0] mf[8];
        ch = '{8'hbf, 8'hc0, 8'hdf, 8'he0};
        ce = '{8'h20, 8'h27, 8'h27, 8'h20};
        ma = '{8'h07, 8'h07, 8'h0f, 8'h01, 8'h09, 8'h70, 8'h70, 8'h1e};
        mf = '{4'h8, 4'h0, 4'h8, 4'h4, 4'h4, 4'h8, 4'h0, 4'h8};
        me = '{8'h27, 8'h20, 8'h2f, 8'h27, 8'h2f, 8'h20, 8'h27, 8'h2f};
        reg_wr(8'h12, 8'h0f);
        reg_wr(8'h10, 8'h00);
        px(3'b010, 4'h0, 8'h41, 8'h9a, 4'h0);
        chk(o_lut_addr, 8'h29);
        px(3'b010, 4'h0, 8'h41, 8'h9a, 4'h8);
        chk(o_lut_addr, 8'h2a);
        px(3'b010, 4'h0, 8'h41, 8'h1e, 4'h8);
        chk(o_lut_addr, 8'h2e);
        px(3'b010, 4'h0, 8'hc0, 8'h07, 4'hb);
        chk(o_lut_addr, 8'h20);
        reg_wr(8'h10, 8'h08);
        px(3'b010, 4'h0, 8'h41, 8'h9a, 4'h0);
        chk(o_lut_addr, 8'h21);
        reg_wr(8'h10, 8'h04);
        for (int i = 0; i < 4; i++) begin
            px(3'b010, 4'h0, ch[i], 8'h07, 4'hb);
            chk(o_lut_addr, ce[i]);
        end
        reg_wr(8'h10, 8'h02);
        for (int i = 0; i < 8; i++) begin
            px(3'b010, 4'h0, 8'h41, ma[i], mf[i]);
            chk(o_lut_addr, me[i]);
        end
        $display("test text done");
    endtask : t_text

    task automatic t_dbl;
        logic [7:0] n, p;
        logic       prev;
        for (int k = 0; k < 2; k++) begin
            reg_wr(8'h10, k == 0 ? 8'h41 : 8'h01);
            settle();
            n    = 8'h00;
            p    = 8'h00;
            prev = 1'b0;
            repeat (8) begin
                @(posedge i_clk);
                #1;
                n    = n + {7'h0, o_pix_adv};
                p    = p | {7'h0, prev & o_pix_adv};
                prev = o_pix_adv;
            end
            chk(n, k == 0 ? 8'h04 : 8'h08);
            chk(p, k == 0 ? 8'h00 : 8'h01);
        end
        $display("test dbl done");
    endtask : t_dbl

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        t_regs();
        t_gfx();
        t_status();
        t_border();
        t_text();
        t_dbl();
        summarize();
    end

    initial begin
        #40000;
        error_cnt++;
        $display("watchdog expired");
        summarize();
    end
endmodule : vga_attribute_pixel_stage_tb
